// file: rtl/core_sfr_pkg.sv
/*
   Package for the core special-function register block: register
   indices, status bit positions, reset values, bus responses, the
   instruction codes that the core hands over and the sequencer states.
   Assumes a 128-byte data-memory bank whose registers sit one to an
   aligned 32-bit bus word (byte address = index * 4).
*/
package core_sfr_pkg;

   // data-memory geometry
   localparam int          IDX_W           = 7;
   localparam int          BYTE_W          = 8;
   localparam int          GPR_DEPTH       = 64;

   // register indices in bank 0
   localparam logic [6:0]  IDX_PORT_FIRST  = 7'h00;
   localparam logic [6:0]  IDX_PTR_FIRST   = 7'h01;
   localparam logic [6:0]  IDX_PORT_SECOND = 7'h02;
   localparam logic [6:0]  IDX_PTR_SECOND  = 7'h03;
   localparam logic [6:0]  IDX_WORKING     = 7'h05;
   localparam logic [6:0]  IDX_PROG_LOW    = 7'h06;
   localparam logic [6:0]  IDX_LOOKUP_PTR  = 7'h07;
   localparam logic [6:0]  IDX_LOOKUP_HIGH = 7'h08;
   localparam logic [6:0]  IDX_STATUS      = 7'h0a;
   localparam logic [6:0]  IDX_GPR_FIRST   = 7'h40;
   localparam logic [6:0]  IDX_GPR_LAST    = 7'h7f;

   // bus word decode: index lives in address bits 8..2
   localparam int          ADDR_LSB        = 2;
   localparam int          ADDR_TOP        = 9;

   // status bit positions
   localparam int          BIT_CARRY       = 0;
   localparam int          BIT_NIBBLE      = 1;
   localparam int          BIT_ZERO        = 2;
   localparam int          BIT_WRAP        = 3;
   localparam int          BIT_SLEEP       = 4;
   localparam int          BIT_DOG         = 5;
   localparam int          BIT_CHAIN       = 6;
   localparam int          BIT_SIGN        = 7;
   // bits that stored data may not touch
   localparam logic [7:0]  STATUS_SYS_MASK = 8'h30;

   // values after reset, and the value that empty locations read
   localparam logic [7:0]  BYTE_RST        = 8'h00;
   localparam logic [7:0]  STATUS_RST      = 8'h00;
   localparam logic [7:0]  READ_EMPTY      = 8'h00;

   // bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // instruction codes from the core's decoder
   typedef enum logic [4:0] {
      OP_NOP   = 5'h00,
      OP_LOADW = 5'h01,
      OP_STORW = 5'h02,
      OP_ADD   = 5'h03,
      OP_ADC   = 5'h04,
      OP_SUB   = 5'h05,
      OP_SBC   = 5'h06,
      OP_AND   = 5'h07,
      OP_OR    = 5'h08,
      OP_XOR   = 5'h09,
      OP_INC   = 5'h0a,
      OP_DEC   = 5'h0b,
      OP_RLC   = 5'h0c,
      OP_RRC   = 5'h0d,
      OP_KICK  = 5'h0e,
      OP_HALT  = 5'h0f,
      OP_TABRD = 5'h10
   } op_type;

   // sequencer: gray along run -> table -> dummy
   typedef enum logic [1:0] {
      SEQ_RUN   = 2'b00,
      SEQ_TABLE = 2'b01,
      SEQ_DUMMY = 2'b11
   } seq_type;

endpackage

// file: rtl/core_special_registers.sv
/*
   Core special-function registers: pointer/port pairs for indirect
   data-memory access, working register, program-counter low byte,
   lookup pointer and high-byte latch, arithmetic status flags and the
   general-purpose bytes of bank 0. The core hands one decoded
   instruction at a time over a valid/ready port; software sees the
   bank over an AXI4-Lite slave.
   Assumes program memory answers a table fetch in the same cycle as the
   request, and that the core follows jump_o and stalls on op_ready_o.
*/
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps

module core_special_registers
   import core_sfr_pkg::*;
#(
   parameter int PMEM_W = 16,
   parameter int PAGE_W = 3
)(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   // axi4-lite write channels
   input  wire logic [31:0]           s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output      logic                  s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output      logic                  s_axi_wready_o,
   output      logic [1:0]            s_axi_bresp_o,
   output      logic                  s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   // axi4-lite read channels
   input  wire logic [31:0]           s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output      logic                  s_axi_arready_o,
   output      logic [31:0]           s_axi_rdata_o,
   output      logic [1:0]            s_axi_rresp_o,
   output      logic                  s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   // decoded instruction from the core
   input  wire logic                  op_valid_i,
   output      logic                  op_ready_o,
   input  wire op_type                op_code_i,
   input  wire logic [6:0]            op_addr_i,
   input  wire logic [7:0]            op_imm_i,
   input  wire logic                  op_imm_sel_i,
   input  wire logic                  op_dest_mem_i,
   // program counter
   input  wire logic [7:0]            pc_low_i,
   input  wire logic [PAGE_W-1:0]     pc_page_i,
   output      logic                  jump_o,
   output      logic [PAGE_W+7:0]     jump_addr_o,
   // program memory for table reads
   output      logic                  pmem_req_o,
   output      logic [PAGE_W+7:0]     pmem_addr_o,
   input  wire logic [PMEM_W-1:0]     pmem_word_i,
   // watchdog and power
   input  wire logic                  dog_timeout_i,
   output      logic                  dog_kick_o,
   output      logic                  halt_o,
   // state view
   output      logic [7:0]            status_o,
   output      logic [7:0]            working_o
);

   initial begin
      if (PMEM_W < 9 || PMEM_W > 16)
         $error("PMEM_W must lie in 9..16");
      if (PAGE_W < 1 || PAGE_W > 8)
         $error("PAGE_W must lie in 1..8");
   end

   // storage
   logic [7:0]    ptr_first_q, ptr_second_q, working_q, lookup_ptr_q;
   logic [7:0]    lookup_high_q, status_q, status_d;
   logic [7:0]    gpr_q [GPR_DEPTH];
   seq_type       seq_q, seq_d;
   logic [6:0]    tab_idx_q;

   // byte read of one bank-0 location, direct view (no redirection)
   function automatic logic [7:0] read_byte(input logic [6:0] idx);
      logic [7:0] v;
      v = READ_EMPTY; // unused and port locations read 00H
      case (idx)
         IDX_PTR_FIRST:   v = ptr_first_q;
         IDX_PTR_SECOND:  v = ptr_second_q;
         IDX_WORKING:     v = working_q;
         IDX_PROG_LOW:    v = pc_low_i;
         IDX_LOOKUP_PTR:  v = lookup_ptr_q;
         IDX_LOOKUP_HIGH: v = lookup_high_q;
         IDX_STATUS:      v = status_q;
         default: begin
            if (idx >= IDX_GPR_FIRST) begin
               v = gpr_q[idx[5:0]];
            end
         end
      endcase
      return v;
   endfunction

   // instruction operand: port locations take the pointer's address;
   // pointer bit 7 is dropped since only bank 0 is reachable
   wire logic       ins_go   = op_valid_i & op_ready_o;
   wire logic       is_port1 = (op_addr_i == IDX_PORT_FIRST);
   wire logic       is_port2 = (op_addr_i == IDX_PORT_SECOND);
   wire logic [6:0] res_idx  = is_port1 ? ptr_first_q[6:0] :
                               is_port2 ? ptr_second_q[6:0] :
                               op_addr_i;
   wire logic [7:0] mem_rd   = read_byte(res_idx);
   wire logic [7:0] oper_b   = op_imm_sel_i ? op_imm_i : mem_rd;

   // alu: every result lands in the working register or in memory
   logic [7:0] alu_res;
   logic       alu_c, alu_ac, alu_ov, alu_z;
   logic       dest_mem, dest_w, fl_arith, fl_zero, fl_carry;
   logic       cz_copy, cz_chain;
   logic [8:0] sum9;
   logic [4:0] sum_lo;
   logic [7:0] sum_hi;
   logic [7:0] b_eff;
   logic       cin;
   always_comb begin
      alu_res  = oper_b;
      dest_mem = 1'b0;
      dest_w   = 1'b0;
      fl_arith = 1'b0;
      fl_zero  = 1'b0;
      fl_carry = 1'b0;
      cz_copy  = 1'b0;
      cz_chain = 1'b0;
      alu_c    = status_q[BIT_CARRY];
      b_eff    = oper_b;
      cin      = 1'b0;
      case (op_code_i)
         OP_SUB, OP_SBC: begin
            b_eff = ~oper_b;
            cin   = (op_code_i == OP_SBC) ? status_q[BIT_CARRY] : 1'b1;
         end
         OP_ADC:  cin = status_q[BIT_CARRY];
         default: cin = 1'b0;
      endcase
      // subtraction as a + ~b + 1, so carry out means no borrow
      sum9   = {1'b0, working_q} + {1'b0, b_eff} + {8'h00, cin};
      sum_lo = {1'b0, working_q[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      sum_hi = {1'b0, working_q[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
      alu_ac = sum_lo[4];
      alu_ov = sum_hi[7] ^ sum9[8];
      case (op_code_i)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
            alu_res  = sum9[7:0];
            alu_c    = sum9[8];
            fl_arith = 1'b1;
            fl_zero  = 1'b1;
            cz_copy  = (op_code_i == OP_ADD) | (op_code_i == OP_SUB);
            cz_chain = (op_code_i == OP_ADC) | (op_code_i == OP_SBC);
         end
         OP_AND, OP_OR, OP_XOR: begin
            alu_res = (op_code_i == OP_AND) ? (working_q & oper_b) :
                      (op_code_i == OP_OR)  ? (working_q | oper_b) :
                                              (working_q ^ oper_b);
            fl_zero = 1'b1;
            cz_copy = 1'b1;
         end
         OP_INC, OP_DEC: begin
            alu_res = (op_code_i == OP_INC) ? (oper_b + 8'h01) :
                                              (oper_b - 8'h01);
            fl_zero = 1'b1;
            cz_copy = 1'b1;
         end
         OP_RLC: begin
            alu_res  = {oper_b[6:0], status_q[BIT_CARRY]};
            alu_c    = oper_b[7];
            fl_carry = 1'b1;
         end
         OP_RRC: begin
            alu_res  = {status_q[BIT_CARRY], oper_b[7:1]};
            alu_c    = oper_b[0];
            fl_carry = 1'b1;
         end
         OP_STORW: alu_res = working_q;
         default:  alu_res = oper_b;
      endcase
      alu_z = (alu_res == 8'h00);
      case (op_code_i)
         OP_LOADW:                   dest_w = 1'b1;
         OP_STORW:                   dest_mem = 1'b1;
         OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
         OP_INC, OP_DEC, OP_RLC, OP_RRC: begin
            dest_mem = op_dest_mem_i & ~op_imm_sel_i;
            dest_w   = ~dest_mem;
         end
         default: dest_w = 1'b0;
      endcase
   end

   // axi write: address and data latched in either order
   logic        aw_have_q, w_have_q, bvalid_q;
   logic [6:0]  aw_idx_q;
   logic        aw_bad_q;
   logic [7:0]  w_byte_q;
   logic        w_lane_q;
   logic [1:0]  bresp_q;
   wire  logic  axi_wr_fire = aw_have_q & w_have_q & ~bvalid_q &
                              ~ins_go & (seq_q == SEQ_RUN);
   wire  logic  axi_wr_port = (aw_idx_q == IDX_PORT_FIRST) |
                              (aw_idx_q == IDX_PORT_SECOND);
   assign s_axi_awready_o = ~aw_have_q;
   assign s_axi_wready_o  = ~w_have_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;

   // one shared write port: table fill, then instruction, then bus
   wire logic       tab_wr  = (seq_q == SEQ_TABLE);
   wire logic       ins_wr  = ins_go & dest_mem;
   wire logic       bus_wr  = axi_wr_fire & ~aw_bad_q & w_lane_q &
                              ~axi_wr_port;
   wire logic       wr_en   = tab_wr | ins_wr | bus_wr;
   wire logic [6:0] wr_idx  = tab_wr ? tab_idx_q :
                              ins_wr ? res_idx : aw_idx_q;
   wire logic [7:0] wr_data = tab_wr ? pmem_word_i[7:0] :
                              ins_wr ? alu_res : w_byte_q;
   wire logic       hit_pcl = wr_en & (wr_idx == IDX_PROG_LOW);

   // bus write latches and response
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         aw_idx_q  <= IDX_PORT_FIRST;
         aw_bad_q  <= 1'b0;
         w_byte_q  <= BYTE_RST;
         w_lane_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr_i[ADDR_TOP-1:ADDR_LSB];
            aw_bad_q  <= |s_axi_awaddr_i[31:ADDR_TOP];
         end
         if (s_axi_wvalid_i && !w_have_q) begin
            w_have_q <= 1'b1;
            w_byte_q <= s_axi_wdata_i[7:0];
            w_lane_q <= s_axi_wstrb_i[0];
         end
         if (axi_wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= aw_bad_q ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // bus read: one outstanding, data registered the cycle after arvalid
   logic        rvalid_q;
   logic [7:0]  rbyte_q;
   logic [1:0]  rresp_q;
   wire  logic  ar_bad  = |s_axi_araddr_i[31:ADDR_TOP];
   wire  logic [6:0] ar_idx = s_axi_araddr_i[ADDR_TOP-1:ADDR_LSB];
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = {24'h000000, rbyte_q};
   assign s_axi_rresp_o   = rresp_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rbyte_q  <= BYTE_RST;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid_i && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rbyte_q  <= ar_bad ? READ_EMPTY : read_byte(ar_idx);
         rresp_q  <= ar_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q && s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // pointers, lookup pointer and general bytes as plain storage
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ptr_first_q  <= BYTE_RST;
         ptr_second_q <= BYTE_RST;
         lookup_ptr_q <= BYTE_RST;
      end else if (wr_en) begin
         if (wr_idx == IDX_PTR_FIRST)  ptr_first_q  <= wr_data;
         if (wr_idx == IDX_PTR_SECOND) ptr_second_q <= wr_data;
         if (wr_idx == IDX_LOOKUP_PTR) lookup_ptr_q <= wr_data;
      end
   end
   // gpr contents are not cleared, like ordinary ram
   always_ff @(posedge clk_i) begin
      if (wr_en && wr_idx >= IDX_GPR_FIRST) begin
         gpr_q[wr_idx[5:0]] <= wr_data;
      end
   end

   // working register: alu results and loads, or a direct write
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         working_q <= BYTE_RST;
      end else if (wr_en && wr_idx == IDX_WORKING) begin
         working_q <= wr_data;
      end else if (ins_go && dest_w) begin
         working_q <= alu_res;
      end
   end

   // status: flags from the alu, then stored data, then system bits;
   // nothing here saves it on calls or interrupts, software must
   always_comb begin
      status_d = status_q;
      if (ins_go && fl_arith) begin
         status_d[BIT_CARRY]  = alu_c;
         status_d[BIT_NIBBLE] = alu_ac;
         status_d[BIT_WRAP]   = alu_ov;
         status_d[BIT_SIGN]   = alu_ov ^ alu_res[7];
      end
      if (ins_go && fl_carry) status_d[BIT_CARRY] = alu_c;
      if (ins_go && fl_zero)  status_d[BIT_ZERO]  = alu_z;
      if (ins_go && cz_copy)  status_d[BIT_CHAIN] = alu_z;
      if (ins_go && cz_chain) begin
         status_d[BIT_CHAIN] = status_q[BIT_CHAIN] & alu_z;
      end
      if (wr_en && wr_idx == IDX_STATUS) begin
         status_d = (wr_data & ~STATUS_SYS_MASK) |
                    (status_q & STATUS_SYS_MASK);
      end
      // clear by kick or halt, a time-out in the same cycle wins
      if (ins_go && (op_code_i == OP_KICK || op_code_i == OP_HALT)) begin
         status_d[BIT_DOG] = 1'b0;
      end
      if (dog_timeout_i) status_d[BIT_DOG] = 1'b1;
      if (ins_go && op_code_i == OP_KICK) begin
         status_d[BIT_SLEEP] = 1'b0;
      end
      if (ins_go && op_code_i == OP_HALT) begin
         status_d[BIT_SLEEP] = 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) status_q <= STATUS_RST;
      else          status_q <= status_d;
   end

   // sequencer: table fetch and jump dummy stall the instruction port
   always_comb begin
      seq_d = SEQ_RUN;
      case (seq_q)
         SEQ_RUN: begin
            if (hit_pcl)                             seq_d = SEQ_DUMMY;
            else if (ins_go && op_code_i == OP_TABRD) seq_d = SEQ_TABLE;
         end
         SEQ_TABLE: seq_d = hit_pcl ? SEQ_DUMMY : SEQ_RUN;
         SEQ_DUMMY: seq_d = SEQ_RUN;
         default:   seq_d = SEQ_RUN;
      endcase
   end
   assign op_ready_o = (seq_q == SEQ_RUN);

   // table word: high byte latched, destination kept for the fill
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         seq_q         <= SEQ_RUN;
         tab_idx_q     <= IDX_PORT_FIRST;
         lookup_high_q <= BYTE_RST;
      end else begin
         seq_q <= seq_d;
         if (ins_go && op_code_i == OP_TABRD) tab_idx_q <= res_idx;
         if (tab_wr) begin
            // shift keeps the width legal for every PMEM_W in 9..16
            lookup_high_q <= 8'(pmem_word_i >> 8);
         end
      end
   end

   // pulses to the core: jump within the page, fetch, kick, halt
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         jump_o      <= 1'b0;
         jump_addr_o <= '0;
         pmem_req_o  <= 1'b0;
         pmem_addr_o <= '0;
         dog_kick_o  <= 1'b0;
         halt_o      <= 1'b0;
      end else begin
         jump_o     <= hit_pcl;
         pmem_req_o <= ins_go & (op_code_i == OP_TABRD);
         dog_kick_o <= ins_go & (op_code_i == OP_KICK);
         halt_o     <= ins_go & (op_code_i == OP_HALT);
         if (hit_pcl) jump_addr_o <= {pc_page_i, wr_data};
         if (ins_go && op_code_i == OP_TABRD) begin
            pmem_addr_o <= {pc_page_i, lookup_ptr_q};
         end
      end
   end

   assign status_o  = status_q;
   assign working_o = working_q;

endmodule

// file: tb/core_special_registers_props.sv
/* Checker for the special-register block: jump, table fetch, flags.
   Assumes the top module's ports and the core_sfr_pkg package. */
`timescale 1ns/10ps
module core_special_registers_chk
   import core_sfr_pkg::*;
#(
   parameter int PMEM_W = 16,
   parameter int PAGE_W = 3
)(
   // clock, reset and instruction port
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              op_valid_i,
   input  wire logic              op_ready_o,
   input  wire op_type            op_code_i,
   input  wire logic [6:0]        op_addr_i,
   input  wire logic              op_imm_sel_i,
   input  wire logic              op_dest_mem_i,
   // program counter, table, power
   input  wire logic [PAGE_W-1:0] pc_page_i,
   input  wire logic              jump_o,
   input  wire logic [PAGE_W+7:0] jump_addr_o,
   input  wire logic              pmem_req_o,
   input  wire logic [PAGE_W+7:0] pmem_addr_o,
   input  wire logic              dog_timeout_i,
   input  wire logic              dog_kick_o,
   input  wire logic              halt_o,
   input  wire logic [7:0]        status_o,
   input  wire logic [7:0]        working_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // accepted instruction, and whether its result lands in working
   wire logic go  = op_valid_i & op_ready_o;
   wire logic to_w = go & (op_imm_sel_i | !op_dest_mem_i);
   wire logic zop = op_code_i inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
   a_dummy_cycle: assert property (jump_o |-> !op_ready_o)
      else $error("no dummy cycle after jump");
   a_jump_target: assert property (go && op_code_i == OP_STORW &&
      op_addr_i == IDX_PROG_LOW |=> jump_o &&
      jump_addr_o == {$past(pc_page_i), $past(working_o)})
      else $error("jump target wrong");
   a_table_fetch: assert property (go && op_code_i == OP_TABRD |=>
      pmem_req_o && !op_ready_o &&
      pmem_addr_o[PAGE_W+7:8] == $past(pc_page_i) ##1 !pmem_req_o)
      else $error("table fetch sequence wrong");
   a_sys_bits: assert property ($changed(status_o[5:4]) |->
      $past(dog_timeout_i || go && op_code_i inside {OP_KICK, OP_HALT}))
      else $error("system bits changed without cause");
   a_dog_set: assert property (dog_timeout_i |=> status_o[BIT_DOG])
      else $error("expiry bit not set");
   a_halt_sleep: assert property (go && op_code_i == OP_HALT |=>
      status_o[BIT_SLEEP] && halt_o)
      else $error("halt did not set sleep bit");
   a_kick_clear: assert property (go && op_code_i == OP_KICK &&
      !dog_timeout_i |=> status_o[5:4] == 2'b00 && dog_kick_o)
      else $error("kick did not clear system bits");
   a_sign_xor: assert property (to_w && op_code_i inside {OP_ADD, OP_SUB}
      |=> status_o[BIT_SIGN] == (status_o[BIT_WRAP] ^ working_o[7]))
      else $error("sign bit wrong");
   a_zero_flag: assert property (to_w && zop |=>
      status_o[BIT_ZERO] == (working_o == 8'h00))
      else $error("zero flag wrong");
   a_chain_copy: assert property (to_w && zop |=>
      status_o[BIT_CHAIN] == status_o[BIT_ZERO])
      else $error("chained zero not copied");
endmodule
bind core_special_registers core_special_registers_chk #(
   .PMEM_W(PMEM_W), .PAGE_W(PAGE_W)) chk (.*);

// file: tb/core_special_registers_test.sv
/* Self-checking bench: bus reads and writes, instructions, flags.
   Assumes the checker is bound to the block from its own file. */
`timescale 1ns/10ps
module core_special_registers_test;
   import core_sfr_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, s_axi_awvalid_i = 1'b0;
   logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, op_valid_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, dog_timeout_i = 1'b0;
   logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   op_type op_code_i = OP_NOP;
   logic [6:0] op_addr_i = '0;
   logic [7:0] op_imm_i = '0, pc_low_i = 8'h5c;
   logic op_imm_sel_i = 1'b0, op_dest_mem_i = 1'b0;
   logic [2:0] pc_page_i = '0;
   logic [15:0] pmem_word_i = '0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
   logic s_axi_rvalid_o, op_ready_o, jump_o, pmem_req_o, dog_kick_o, halt_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_rdata_o;
   logic [10:0] jump_addr_o, pmem_addr_o;
   logic [7:0] status_o, working_o;
   logic [33:0] rq[$], bq[$], jq[$];
   logic [31:0] seed = 32'hc0e6;
   int n_errors = 0, num_checks = 0;
   core_special_registers dut (.*);
   always #5 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(logic [33:0] g, logic [33:0] e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   // bound wait: running out counts as a mismatch and ends the run
   task automatic lim(int n);
      if (n >= 50) begin
         n_errors++;
         conclude();
      end
   endtask
   // bus write; aw and w released one by one as each is taken
   task automatic wr(logic [31:0] a, logic [7:0] d, logic [1:0] r);
      int n;
      bit aw, w, b;
      bq.push_back(34'(r));
      op_valid_i <= 1'b0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h0, d};
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
      do begin
         @(negedge clk_i);
         aw = s_axi_awready_o;
         w = s_axi_wready_o;
         b = s_axi_bvalid_o;
         @(posedge clk_i);
         if (aw) s_axi_awvalid_i <= 1'b0;
         if (w) s_axi_wvalid_i <= 1'b0;
         n++;
      end while (!b && n < 50);
      s_axi_bready_i <= 1'b0;
      lim(n);
   endtask
   task automatic rd(logic [31:0] a, logic [7:0] d, logic [1:0] r);
      int n;
      bit ar, v;
      rq.push_back({r, 24'h0, d});
      op_valid_i <= 1'b0;
      s_axi_araddr_i <= a;
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
      do begin
         @(negedge clk_i);
         ar = s_axi_arready_o;
         v = s_axi_rvalid_o;
         @(posedge clk_i);
         if (ar) s_axi_arvalid_i <= 1'b0;
         n++;
      end while (!v && n < 50);
      s_axi_rready_i <= 1'b0;
      lim(n);
   endtask
   // instruction offered until taken; valid stays up for the next one
   task automatic op(op_type c, logic [6:0] a, logic [7:0] d, logic s);
      int n;
      op_code_i <= c;
      op_addr_i <= a;
      op_imm_i <= d;
      op_imm_sel_i <= s;
      op_dest_mem_i <= (c == OP_TABRD);
      op_valid_i <= 1'b1;
      do begin
         @(negedge clk_i);
         n++;
      end while (!op_ready_o && n < 50);
      @(posedge clk_i);
      lim(n);
   endtask
   // results are compared in order of appearance
   always @(posedge clk_i) begin
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
         cmp({s_axi_rresp_o, s_axi_rdata_o}, rq.pop_front());
      if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i)
         cmp(34'(s_axi_bresp_o), bq.pop_front());
      if (jump_o === 1'b1) cmp(34'(jump_addr_o), jq.pop_front());
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      rd(32'h28, 8'h00, RESP_OKAY);
      seed = lfsr(seed);
      wr(32'h100, seed[7:0], RESP_OKAY);
      rd(32'h100, seed[7:0], RESP_OKAY);
      wr(32'h04, 8'h41, RESP_OKAY);
      rd(32'h04, 8'h41, RESP_OKAY);
      wr(32'h00, 8'h5a, RESP_OKAY);
      rd(32'h00, 8'h00, RESP_OKAY);
      wr(32'h200, 8'h11, RESP_SLVERR);
      rd(32'h200, 8'h00, RESP_SLVERR);
      $display("bus map done");
      op(OP_LOADW, 7'h00, 8'h3c, 1'b1);
      op(OP_STORW, IDX_PORT_FIRST, 8'h00, 1'b0);
      op(OP_LOADW, 7'h00, 8'h00, 1'b1);
      op(OP_LOADW, IDX_PORT_FIRST, 8'h00, 1'b0);
      rd(32'h104, 8'h3c, RESP_OKAY);
      rd(32'h14, 8'h3c, RESP_OKAY);
      op(OP_LOADW, 7'h00, 8'h7f, 1'b1);
      op(OP_ADD, 7'h00, 8'h01, 1'b1);
      rd(32'h28, 8'h0a, RESP_OKAY);
      op(OP_SUB, 7'h00, 8'h80, 1'b1);
      rd(32'h28, 8'h47, RESP_OKAY);
      $display("indirect and flags done");
      wr(32'h28, 8'hff, RESP_OKAY);
      rd(32'h28, 8'hcf, RESP_OKAY);
      op(OP_HALT, 7'h00, 8'h00, 1'b0);
      rd(32'h28, 8'hdf, RESP_OKAY);
      dog_timeout_i <= 1'b1;
      @(posedge clk_i);
      dog_timeout_i <= 1'b0;
      rd(32'h28, 8'hff, RESP_OKAY);
      op(OP_KICK, 7'h00, 8'h00, 1'b0);
      rd(32'h28, 8'hcf, RESP_OKAY);
      $display("system bits done");
      seed = lfsr(seed);
      pc_page_i <= seed[2:0];
      pmem_word_i <= seed[31:16];
      jq.push_back(34'({seed[2:0], 8'h21}));
      op(OP_LOADW, 7'h00, 8'h21, 1'b1);
      op(OP_STORW, IDX_PROG_LOW, 8'h00, 1'b0);
      op(OP_STORW, IDX_LOOKUP_PTR, 8'h00, 1'b0);
      op(OP_TABRD, 7'h42, 8'h00, 1'b0);
      // the fill lands one edge after the fetch request
      repeat (2) @(posedge clk_i);
      rd(32'h108, seed[23:16], RESP_OKAY);
      rd(32'h20, seed[31:24], RESP_OKAY);
      rd(32'h18, 8'h5c, RESP_OKAY);
      $display("jump and table done");
      repeat (2) @(posedge clk_i);
      conclude();
   end
endmodule
